// file: twe_cfg.svh
`ifndef TWE_CFG_SVH
`define TWE_CFG_SVH
// Register byte offsets
`define TWE_OFF_CTRL 4'h0
`define TWE_OFF_STAT 4'h4
`define TWE_OFF_DATA 4'h8
`define TWE_OFF_ADDR 4'hC
// Control register bit positions
`define TWE_B_AA 2
`define TWE_B_SI 3
`define TWE_B_STO 4
`define TWE_B_STA 5
`define TWE_B_ENA 6
`define TWE_CTRL_RST 5'h00
// Status codes
`define TWE_ST_NONE 8'hF8
`define TWE_ST_BERR 8'h00
`define TWE_ST_START 8'h08
`define TWE_ST_AW_ACK 8'h18
`define TWE_ST_AW_NAK 8'h20
`define TWE_ST_D_ACK 8'h28
`define TWE_ST_D_NAK 8'h30
`define TWE_ST_ARB 8'h38
`define TWE_ST_AR_ACK 8'h40
`define TWE_ST_AR_NAK 8'h48
`define TWE_ST_STX 8'hA8
`define TWE_ST_ARB_STX 8'hB0
`define TWE_ST_TX_ACK 8'hB8
`define TWE_ST_TX_NAK 8'hC0
`define TWE_ST_TX_LAST 8'hC8
// Timing: quarter of a serial clock period
`define TWE_CLK_NS 5
`define TWE_QTR_NS 2500
`define TWE_QTR_CYC ((`TWE_QTR_NS + `TWE_CLK_NS - 1) / `TWE_CLK_NS)
`endif

// file: twe_pkg.sv
package twe_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_SADDR, ST_SACK, ST_SHOLD, ST_STX, ST_SRACK,
		ST_MSTART, ST_MHOLD, ST_MBIT, ST_MSTOP, ST_XCLK
	} twe_state_t;
	typedef struct packed {
		logic ena;
		logic start_request_flag;
		logic stop_request_flag;
		logic si;
		logic aa;
	} twe_ctrl_t;
endpackage : twe_pkg

// file: twe_ctrl.sv
// Overview of operation
// (R01) Status reads F8H while interrupt flag clear
// (R02) Misplaced START/STOP gives bus error 00H
// (R03) Software recovers: set stop, clear flag
// (R04) Recovery clears stop only, not addressed
// (R05) Recovery releases lines, sends no STOP
// (R06) Own address with read enters slave transmit
// (R07) Lost arbitration then own read gives B0H
// (R08) Ack-enable cleared: last byte, C0H/C8H
// (R09) Afterwards ignore master, SDA released
// (R10) Ack-enable clear ignores own address
// (R11) Foreign repeated START: back off, no interrupt
// (R12) After their STOP send START, 08H
// (R13) Lost arbitration reported by dedicated codes
// (R14) Start request after loss retries when free
// (R15) Stop with start pending forces bus free
// (R16) Software uses forced access on hung bus
// (R17) SCL held low simply stalls transfers
// (R18) SDA low: extra clocks, retry every two
// (R19) SDA freed: START, 08H, continue alone
// (R20) Same recovery for forced or repeated START
// (R21) Bus error only as master or addressed
// (R22) Interrupt request follows the serial flag
`include "twe_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module twe_ctrl import twe_pkg::*; #(
	parameter int QTR_CYC = `TWE_QTR_CYC
) (
	input wire logic clock_i, // System clock
	input wire logic reset_i, // Synchronous reset
	input wire logic [3:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Wait request
	input wire logic scl_i, // Clock line level
	output logic scl_o, // Clock line drive value
	output logic scl_oe_o, // Clock line pulled low
	input wire logic sda_i, // Data line level
	output logic sda_o, // Data line drive value
	output logic sda_oe_o, // Data line pulled low
	output logic irq_o // Interrupt request
);
	twe_ctrl_t ctrl_reg;
	twe_state_t st_reg;
	logic [1:0] scl_sync_reg, sda_sync_reg;
	logic scl_d_reg, sda_d_reg, busy_reg, ack_reg;
	logic [15:0] qcnt_reg;
	logic [7:0] data_reg, own_reg, code_reg, sh_reg;
	logic [1:0] ph_reg;
	logic [3:0] bit_reg;
	logic scl_oe_reg, sda_oe_reg, si_set_reg, sto_done_reg;
	logic lost_reg, last_reg, aph_reg, xcnt_reg, nack_reg;
	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, tick;
	logic wr_en, rd_acc, idle_sto, force_free, si_clear, addressed;
	logic [7:0] stat_val;

	// Line synchronisers and edge history
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
		end
	end

	// Bus condition detection
	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// Bus busy tracking; a forced access frees it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			busy_reg <= 1'b0;
		end else if (stop_det || force_free) begin
			busy_reg <= 1'b0; // R15
		end else if (start_det) begin
			busy_reg <= 1'b1;
		end
	end

	// Quarter bit-time enable
	always_ff @(posedge clock_i) begin
		if (reset_i || qcnt_reg == 16'(QTR_CYC - 1)) begin
			qcnt_reg <= 16'h0000;
		end else begin
			qcnt_reg <= qcnt_reg + 16'h0001;
		end
	end
	assign tick = (qcnt_reg == 16'h0000);

	// Bus slave handshake: one wait cycle per access
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
	assign wr_en = avs_write_i & ack_reg;
	assign rd_acc = avs_read_i & ~ack_reg;
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
		end
	end

	// Status reads the idle code while the flag is clear
	assign stat_val = ctrl_reg.si ? code_reg : `TWE_ST_NONE; // R01

	// Read data register
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (rd_acc) begin
			unique case (avs_address_i)
				`TWE_OFF_CTRL: avs_readdata_o <= {25'h0, ctrl_reg.ena, ctrl_reg.start_request_flag,
					ctrl_reg.stop_request_flag, ctrl_reg.si, ctrl_reg.aa, 2'h0};
				`TWE_OFF_STAT: avs_readdata_o <= {24'h0, stat_val};
				`TWE_OFF_DATA: avs_readdata_o <= {24'h0, data_reg};
				`TWE_OFF_ADDR: avs_readdata_o <= {24'h0, own_reg};
				default: avs_readdata_o <= 32'h00000000;
			endcase
		end
	end

	// Data and own address registers
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			data_reg <= 8'h00;
			own_reg <= 8'h00;
		end else if (wr_en && avs_address_i == `TWE_OFF_DATA) begin
			data_reg <= avs_writedata_i[7:0];
		end else if (wr_en && avs_address_i == `TWE_OFF_ADDR) begin
			own_reg <= avs_writedata_i[7:0];
		end
	end

	// Hardware stop clear and forced access; a slave still watching for its address counts as idle
	assign idle_sto = (st_reg == ST_IDLE || st_reg == ST_SADDR) & ctrl_reg.stop_request_flag & ~ctrl_reg.si &
		~si_set_reg;
	assign force_free = idle_sto & ctrl_reg.start_request_flag & busy_reg; // R15
	assign si_clear = ~ctrl_reg.si & ~si_set_reg;

	// Control register; a hardware flag set beats a software clear
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ctrl_reg <= `TWE_CTRL_RST;
		end else begin
			if (wr_en && avs_address_i == `TWE_OFF_CTRL) begin
				ctrl_reg.ena <= avs_writedata_i[`TWE_B_ENA];
				ctrl_reg.start_request_flag <= avs_writedata_i[`TWE_B_STA];
				ctrl_reg.stop_request_flag <= avs_writedata_i[`TWE_B_STO];
				ctrl_reg.si <= ctrl_reg.si & avs_writedata_i[`TWE_B_SI];
				ctrl_reg.aa <= avs_writedata_i[`TWE_B_AA];
			end
			if (idle_sto || sto_done_reg) begin
				ctrl_reg.stop_request_flag <= 1'b0; // R04
			end
			if (si_set_reg) begin
				ctrl_reg.si <= 1'b1;
			end
		end
	end
	assign irq_o = ctrl_reg.si; // R22

	// Master byte transfer or hold state, or addressed slave role
	assign addressed = st_reg inside {ST_SACK, ST_SHOLD, ST_STX, ST_SRACK, ST_MBIT, ST_MHOLD};

	// Main sequencer
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st_reg <= ST_IDLE;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			code_reg <= `TWE_ST_NONE;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			si_set_reg <= 1'b0;
			sto_done_reg <= 1'b0;
			lost_reg <= 1'b0;
			last_reg <= 1'b0;
			aph_reg <= 1'b0;
			xcnt_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			si_set_reg <= 1'b0;
			sto_done_reg <= 1'b0;
			if (addressed && (start_det || stop_det)) begin
				st_reg <= ST_IDLE; // R21
				scl_oe_reg <= 1'b0; // R05
				sda_oe_reg <= 1'b0;
				code_reg <= `TWE_ST_BERR; // R02
				si_set_reg <= 1'b1;
			end else begin
				unique case (st_reg)
					ST_IDLE: begin
						scl_oe_reg <= 1'b0;
						sda_oe_reg <= 1'b0;
						ph_reg <= 2'h0;
						xcnt_reg <= 1'b0;
						if (ctrl_reg.ena && start_det) begin
							st_reg <= ST_SADDR;
							bit_reg <= 4'h0;
							lost_reg <= 1'b0;
						end else if (ctrl_reg.ena && ctrl_reg.start_request_flag && si_clear &&
							!busy_reg && !ctrl_reg.stop_request_flag) begin
							st_reg <= sda_s ? ST_MSTART : ST_XCLK; // R14
						end
					end
					ST_SADDR: begin
						if (stop_det || idle_sto) begin
							st_reg <= ST_IDLE; // R15
						end else if (start_det) begin
							bit_reg <= 4'h0;
						end else if (scl_rise && bit_reg < 4'h8) begin
							sh_reg <= {sh_reg[6:0], sda_s};
							bit_reg <= bit_reg + 4'h1;
						end else if (scl_fall && bit_reg == 4'h8) begin
							if (ctrl_reg.aa && sh_reg[7:1] == own_reg[7:1] && sh_reg[0]) begin
								sda_oe_reg <= 1'b1; // R10
								st_reg <= ST_SACK;
							end else begin
								st_reg <= ST_IDLE;
								if (lost_reg) begin
									code_reg <= `TWE_ST_ARB; // R13
									si_set_reg <= 1'b1;
								end
							end
						end
					end
					ST_SACK: begin
						if (scl_fall) begin
							sda_oe_reg <= 1'b0;
							scl_oe_reg <= 1'b1;
							code_reg <= lost_reg ? `TWE_ST_ARB_STX : `TWE_ST_STX; // R07
							si_set_reg <= 1'b1; // R06
							st_reg <= ST_SHOLD;
						end
					end
					ST_SHOLD: begin
						scl_oe_reg <= 1'b1;
						if (si_clear) begin
							sh_reg <= data_reg;
							last_reg <= ~ctrl_reg.aa; // R08
							bit_reg <= 4'h0;
							sda_oe_reg <= ~data_reg[7];
							st_reg <= ST_STX;
						end
					end
					ST_STX: begin
						if (scl_oe_reg && tick) begin
							scl_oe_reg <= 1'b0;
						end
						if (scl_fall) begin
							bit_reg <= bit_reg + 4'h1;
							sh_reg <= {sh_reg[6:0], 1'b1};
							sda_oe_reg <= (bit_reg == 4'h7) ? 1'b0 : ~sh_reg[6];
							if (bit_reg == 4'h7) begin
								st_reg <= ST_SRACK;
							end
						end
					end
					ST_SRACK: begin
						if (scl_rise) begin
							nack_reg <= sda_s;
						end else if (scl_fall) begin
							si_set_reg <= 1'b1;
							if (nack_reg) begin
								code_reg <= `TWE_ST_TX_NAK;
								st_reg <= ST_IDLE;
							end else if (last_reg) begin
								code_reg <= `TWE_ST_TX_LAST; // R08
								st_reg <= ST_IDLE; // R09
							end else begin
								code_reg <= `TWE_ST_TX_ACK;
								scl_oe_reg <= 1'b1;
								st_reg <= ST_SHOLD;
							end
						end
					end
					ST_MSTART: begin
						if (start_det && !sda_oe_reg) begin
							scl_oe_reg <= 1'b0; // R11
							sda_oe_reg <= 1'b0;
							bit_reg <= 4'h0;
							lost_reg <= 1'b0;
							st_reg <= ST_SADDR;
						end else if (tick) begin
							unique case (ph_reg)
								2'h0: begin
									sda_oe_reg <= 1'b0;
									ph_reg <= 2'h1;
								end
								2'h1: begin
									scl_oe_reg <= 1'b0;
									ph_reg <= 2'h2;
								end
								2'h2: begin
									if (scl_s && sda_s) begin
										sda_oe_reg <= 1'b1;
										ph_reg <= 2'h3;
									end else if (scl_s) begin
										ph_reg <= 2'h0; // R20
										xcnt_reg <= 1'b0;
										st_reg <= ST_XCLK;
									end
								end
								2'h3: begin
									scl_oe_reg <= 1'b1;
									code_reg <= `TWE_ST_START; // R19
									si_set_reg <= 1'b1; // R12
									aph_reg <= 1'b1;
									st_reg <= ST_MHOLD;
								end
							endcase
						end
					end
					ST_XCLK: begin
						if (tick) begin
							unique case (ph_reg)
								2'h0: begin
									scl_oe_reg <= 1'b1;
									ph_reg <= 2'h1;
								end
								2'h1: begin
									ph_reg <= 2'h2;
								end
								2'h2: begin
									scl_oe_reg <= 1'b0;
									ph_reg <= 2'h3;
								end
								2'h3: begin
									if (scl_s) begin
										xcnt_reg <= ~xcnt_reg;
										ph_reg <= xcnt_reg ? 2'h2 : 2'h0; // R18
										if (xcnt_reg) begin
											st_reg <= ST_MSTART;
										end
									end
								end
							endcase
						end
					end
					ST_MHOLD: begin
						scl_oe_reg <= 1'b1;
						ph_reg <= 2'h0;
						if (si_clear) begin
							if (ctrl_reg.stop_request_flag) begin
								st_reg <= ST_MSTOP;
							end else if (ctrl_reg.start_request_flag) begin
								st_reg <= ST_MSTART;
							end else begin
								sh_reg <= data_reg;
								bit_reg <= 4'h0;
								st_reg <= ST_MBIT;
							end
						end
					end
					ST_MBIT: begin
						if (tick) begin
							unique case (ph_reg)
								2'h0: begin
									sda_oe_reg <= (bit_reg < 4'h8) & ~sh_reg[7];
									ph_reg <= 2'h1;
								end
								2'h1: begin
									scl_oe_reg <= 1'b0;
									ph_reg <= 2'h2;
								end
								2'h2: begin
									if (scl_s) begin // R17
										ph_reg <= 2'h3;
										if (bit_reg == 4'h8) begin
											nack_reg <= sda_s;
										end else begin
											sh_reg <= {sh_reg[6:0], sda_s};
											if (!sda_oe_reg && !sda_s) begin
												sda_oe_reg <= 1'b0;
												bit_reg <= bit_reg + 4'h1;
												lost_reg <= aph_reg;
												st_reg <= aph_reg ? ST_SADDR : ST_IDLE;
												code_reg <= `TWE_ST_ARB; // R13
												si_set_reg <= ~aph_reg;
											end
										end
									end
								end
								2'h3: begin
									scl_oe_reg <= 1'b1;
									ph_reg <= 2'h0;
									bit_reg <= bit_reg + 4'h1;
									if (bit_reg == 4'h8) begin
										si_set_reg <= 1'b1;
										aph_reg <= 1'b0;
										st_reg <= ST_MHOLD;
										if (aph_reg && sh_reg[0]) begin
											code_reg <= nack_reg ? `TWE_ST_AR_NAK : `TWE_ST_AR_ACK;
										end else if (aph_reg) begin
											code_reg <= nack_reg ? `TWE_ST_AW_NAK : `TWE_ST_AW_ACK;
										end else begin
											code_reg <= nack_reg ? `TWE_ST_D_NAK : `TWE_ST_D_ACK;
										end
									end
								end
							endcase
						end
					end
					ST_MSTOP: begin
						if (tick) begin
							unique case (ph_reg)
								2'h0: begin
									sda_oe_reg <= 1'b1;
									ph_reg <= 2'h1;
								end
								2'h1: begin
									scl_oe_reg <= 1'b0;
									ph_reg <= 2'h2;
								end
								2'h2: begin
									if (scl_s) begin
										sda_oe_reg <= 1'b0;
										ph_reg <= 2'h3;
									end
								end
								2'h3: begin
									sto_done_reg <= 1'b1;
									st_reg <= ST_IDLE;
								end
							endcase
						end
					end
				endcase
			end
		end
	end

	// Open-drain pins drive low only
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_oe_reg;
	assign sda_oe_o = sda_oe_reg;

	// Checks
	sequence seq_start_done;
		st_reg == ST_MSTART && ph_reg == 2'h3 && tick && !start_det;
	endsequence
	sequence seq_start_report;
		si_set_reg && code_reg == `TWE_ST_START ##1 ctrl_reg.si;
	endsequence
	AST_STATUS_IDLE: assert property (@(posedge clock_i) disable iff (reset_i) // R01
		rd_acc && avs_address_i == `TWE_OFF_STAT && !ctrl_reg.si
		|=> avs_readdata_o == 32'h000000F8) else $error("status not idle code");
	AST_BUS_ERR: assert property (@(posedge clock_i) disable iff (reset_i) // R02
		addressed && (start_det || stop_det)
		|=> si_set_reg && code_reg == `TWE_ST_BERR ##1 ctrl_reg.si) else $error("no bus error");
	AST_ERR_RELEASE: assert property (@(posedge clock_i) disable iff (reset_i) // R05
		addressed && stop_det |=> !scl_oe_reg && !sda_oe_reg && st_reg == ST_IDLE)
		else $error("lines not released");
	AST_STO_CLR: assert property (@(posedge clock_i) disable iff (reset_i) // R04
		idle_sto && !wr_en |=> !ctrl_reg.stop_request_flag && $stable(ctrl_reg.aa) && $stable(ctrl_reg.ena))
		else $error("stop flag not cleared");
	AST_SLV_TX: assert property (@(posedge clock_i) disable iff (reset_i) // R06
		st_reg == ST_SACK && scl_fall && !start_det && !stop_det
		|=> si_set_reg && st_reg == ST_SHOLD && (code_reg == 8'hA8 || code_reg == 8'hB0))
		else $error("slave transmit not entered");
	AST_LAST: assert property (@(posedge clock_i) disable iff (reset_i) // R08
		st_reg == ST_SRACK && scl_fall && last_reg && !nack_reg && !start_det && !stop_det
		|=> code_reg == `TWE_ST_TX_LAST && st_reg == ST_IDLE) else $error("last byte code");
	AST_NO_DRIVE: assert property (@(posedge clock_i) disable iff (reset_i) // R09
		st_reg == ST_IDLE |-> !sda_oe_reg) else $error("data driven while not addressed");
	AST_BACKOFF: assert property (@(posedge clock_i) disable iff (reset_i) // R11
		st_reg == ST_MSTART && start_det && !sda_oe_reg
		|=> !si_set_reg && !scl_oe_reg && st_reg == ST_SADDR) else $error("no back off");
	AST_START08: assert property (@(posedge clock_i) disable iff (reset_i) // R19
		seq_start_done |=> seq_start_report) else $error("start not reported");
	AST_FORCE: assert property (@(posedge clock_i) disable iff (reset_i) // R15
		force_free |=> !busy_reg && !ctrl_reg.stop_request_flag) else $error("forced access failed");
endmodule : twe_ctrl
`default_nettype wire

// file: twe_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Other master on the open-drain two-wire bus; it only ever pulls lines low
module twe_bus_model (
	input wire logic clock_i, // System clock
	input wire logic scl_i, // Clock line level
	input wire logic sda_i, // Data line level
	output logic scl_oe_o, // Pulls clock line low
	output logic sda_oe_o // Pulls data line low
);
	localparam int Q = 8; // Quarter of a 160 ns link period
	int late = 0; // Clock stretch waits that ran out
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	task automatic qtr();
		repeat (Q) @(posedge clock_i);
	endtask : qtr
	// Release SCL, then wait while a slave stretches it low
	task automatic rise();
		int n;
		n = 0;
		scl_oe_o <= 1'b0;
		do begin
			@(posedge clock_i);
			n++;
		end while (scl_i !== 1'b1 && n < 4000);
		if (n >= 4000) late++;
		qtr();
	endtask : rise
	// SDA falls while SCL is high
	task automatic start();
		sda_oe_o <= 1'b0;
		qtr();
		rise();
		sda_oe_o <= 1'b1;
		qtr();
		scl_oe_o <= 1'b1;
		qtr();
	endtask : start
	// SDA rises while SCL is high
	task automatic stop();
		sda_oe_o <= 1'b1;
		qtr();
		rise();
		sda_oe_o <= 1'b0;
		qtr();
	endtask : stop
	task automatic put_bit(input logic b);
		sda_oe_o <= ~b;
		qtr();
		rise();
		scl_oe_o <= 1'b1;
		qtr();
	endtask : put_bit
	task automatic get_bit(output logic b);
		sda_oe_o <= 1'b0;
		qtr();
		rise();
		b = sda_i;
		scl_oe_o <= 1'b1;
		qtr();
	endtask : get_bit
	// Bytes travel MSB first
	task automatic put_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
	endtask : put_byte
	task automatic get_byte(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) get_bit(v[i]);
	endtask : get_byte
	// Leave the bus busy after a START with SDA stuck low
	task automatic hang();
		scl_oe_o <= 1'b0;
		qtr();
	endtask : hang
	task automatic let_go();
		sda_oe_o <= 1'b0;
	endtask : let_go
endmodule : twe_bus_model
`default_nettype wire

// file: twe_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "twe_cfg.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_total++; \
	$display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module twe_ctrl_tb;
	localparam logic [3:0] CT = `TWE_OFF_CTRL;
	localparam logic [3:0] ST = `TWE_OFF_STAT;
	localparam logic [3:0] DT = `TWE_OFF_DATA;
	localparam logic [3:0] AD = `TWE_OFF_ADDR;
	localparam logic [31:0] EN = 32'h40;
	localparam logic [31:0] AA = 32'h04;
	localparam logic [31:0] SI = 32'h08;
	localparam logic [31:0] STOP_REQUEST_FLAG = 32'h10;
	localparam logic [31:0] START_REQUEST_FLAG = 32'h20;
	typedef struct packed {logic [3:0] a; logic [31:0] w; logic [31:0] e;} twe_row_t;
	// Register table rows: offset, write value, value read back
	twe_row_t rows [5] = '{'{CT, EN | AA, EN | AA}, '{AD, 32'hABCD0074, 32'h74},
		'{DT, 32'h5A, 32'h5A}, '{ST, 32'h12, 32'hF8}, '{4'h1, 32'hFF, 32'h0}};
	logic clock_i;
	logic reset_i;
	logic avs_read_i;
	logic avs_write_i;
	logic [3:0] avs_address_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] rd;
	wire logic [31:0] avs_readdata_o;
	wire logic avs_waitrequest_o, scl_oe_o, sda_oe_o, irq_o, m_scl, m_sda, scl_w, sda_w;
	int err_total = 0;
	int compares = 0;
	int n;
	logic b, p;
	logic [7:0] d;
	// Open-drain lines with pull-ups
	assign scl_w = ~(scl_oe_o | m_scl);
	assign sda_w = ~(sda_oe_o | m_sda);
	twe_ctrl #(.QTR_CYC(4)) twe_ctrl_i (.clock_i(clock_i), .reset_i(reset_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe_o),
		.sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
	twe_bus_model twe_bus_model_i (.clock_i(clock_i), .scl_i(scl_w), .sda_i(sda_w),
		.scl_oe_o(m_scl), .sda_oe_o(m_sda));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	task automatic wrap_up();
		$display("Counts: %0d mismatches in %0d compares", err_total, compares);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] w);
		int k;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= w;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		k = 0;
		do begin
			@(posedge clock_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 50);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (k >= 50) begin
			err_total++;
			wrap_up();
		end
	endtask : bus
	// Bounded wait for the interrupt request
	task automatic wait_irq();
		int k;
		k = 0;
		while (irq_o !== 1'b1 && k < 20000) begin
			@(posedge clock_i);
			k++;
		end
		if (k >= 20000) begin
			err_total++;
			wrap_up();
		end
	endtask : wait_irq
	initial begin
		reset_i <= 1'b1;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		avs_address_i <= 4'h0;
		avs_writedata_i <= 32'h0;
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		bus(0, ST, 0);
		`CHK("status idle", 32'hF8, rd)
		`CHK("irq idle", 1'b0, irq_o)
		foreach (rows[i]) begin
			bus(1, rows[i].a, rows[i].w);
			bus(0, rows[i].a, 0);
			`CHK("register", rows[i].e, rd)
		end
		// Own address with read, then a last byte after ack-enable is cleared
		twe_bus_model_i.start();
		twe_bus_model_i.put_byte(8'h75);
		twe_bus_model_i.get_bit(b);
		`CHK("address ack", 1'b0, b)
		wait_irq();
		bus(0, ST, 0);
		`CHK("status addressed", 32'hA8, rd)
		`CHK("irq addressed", 1'b1, irq_o)
		bus(1, DT, 32'h96);
		bus(1, CT, EN);
		twe_bus_model_i.get_byte(d);
		`CHK("sent byte", 8'h96, d)
		twe_bus_model_i.put_bit(1'b0);
		wait_irq();
		bus(0, ST, 0);
		`CHK("status last", 32'hC8, rd)
		bus(1, CT, EN | AA);
		twe_bus_model_i.get_byte(d);
		`CHK("after last", 8'hFF, d)
		twe_bus_model_i.put_bit(1'b1);
		twe_bus_model_i.stop();
		// Ack-enable clear: own address not answered
		bus(1, CT, EN);
		twe_bus_model_i.start();
		twe_bus_model_i.put_byte(8'h75);
		twe_bus_model_i.get_bit(b);
		twe_bus_model_i.stop();
		`CHK("isolated ack", 1'b1, b)
		`CHK("isolated irq", 1'b0, irq_o)
		// Misplaced START while not addressed is ignored
		bus(1, CT, EN | AA);
		twe_bus_model_i.start();
		repeat (3) twe_bus_model_i.put_bit(1'b0);
		twe_bus_model_i.start();
		twe_bus_model_i.stop();
		`CHK("foreign error irq", 1'b0, irq_o)
		// START inside a transmitted byte while addressed
		twe_bus_model_i.start();
		twe_bus_model_i.put_byte(8'h75);
		twe_bus_model_i.get_bit(b);
		wait_irq();
		bus(1, DT, 32'hFF);
		bus(1, CT, EN | AA);
		repeat (3) twe_bus_model_i.get_bit(b);
		twe_bus_model_i.start();
		wait_irq();
		bus(0, ST, 0);
		`CHK("bus error code", 32'h00, rd)
		`CHK("lines freed", 2'b00, {scl_oe_o, sda_oe_o})
		bus(1, CT, EN | STOP_REQUEST_FLAG | AA);
		bus(0, CT, 0);
		`CHK("recovered ctrl", EN | AA, rd)
		`CHK("recovered irq", 1'b0, irq_o)
		`CHK("no stop sent", 2'b00, {scl_oe_o, sda_oe_o})
		twe_bus_model_i.stop();
		// Hung bus with SDA low: forced access, extra clocks, then START
		twe_bus_model_i.start();
		twe_bus_model_i.hang();
		bus(1, CT, EN | START_REQUEST_FLAG | AA);
		repeat (200) @(posedge clock_i);
		`CHK("busy no start", 1'b0, irq_o)
		bus(1, CT, EN | START_REQUEST_FLAG | STOP_REQUEST_FLAG | AA);
		n = 0;
		p = 1'b0;
		for (int k = 0; k < 5000 && n < 2; k++) begin
			@(posedge clock_i);
			if (scl_oe_o === 1'b1 && p === 1'b0) n++;
			p = scl_oe_o;
		end
		`CHK("extra clocks", 2, n)
		twe_bus_model_i.let_go();
		wait_irq();
		bus(0, ST, 0);
		`CHK("start sent", 32'h08, rd)
		bus(0, CT, 0);
		`CHK("forced ctrl", EN | START_REQUEST_FLAG | SI | AA, rd)
		`CHK("link stalls", 0, twe_bus_model_i.late)
		// Address byte lost to the other master, which then reads from us
		bus(1, DT, 32'hF5);
		bus(1, CT, EN | AA);
		twe_bus_model_i.put_byte(8'h75);
		twe_bus_model_i.get_bit(b);
		`CHK("arbitration ack", 1'b0, b)
		wait_irq();
		bus(0, ST, 0);
		`CHK("arbitration status", 32'hB0, rd)
		`CHK("arbitration irq", 1'b1, irq_o)
		// Reset in mid-transfer returns to the idle state
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		bus(0, ST, 0);
		`CHK("status reset", 32'hF8, rd)
		`CHK("irq reset", 1'b0, irq_o)
		wrap_up();
	end
endmodule : twe_ctrl_tb
`default_nettype wire
